// ### ssc_pkg.sv
// constants and state encoding shared by the serial channel and its divider
package ssc_pkg;

    // ==========================================================
    // controller states (one-hot)
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,                           // master waiting for data
        ST_MRUN = 3'h2,                           // master frame running
        ST_SRUN = 3'h4                            // slave armed, follows the select
    } chan_state_t;

    // ==========================================================
    // frame geometry
    localparam logic [3:0] LAST_BIT_IDX    = 4'h7;   // index of the eighth sample
    localparam logic [4:0] EDGES_PER_FRAME = 5'h10;  // sixteen clock edges per byte
    localparam logic [4:0] TAIL_TICK_PH0   = 5'h0F;  // phase 0: last bit held one bit time
    localparam logic [4:0] TAIL_TICK_PH1   = 5'h10;  // phase 1: last bit held one bit time
    localparam logic [4:0] NO_SHIFT_TICK   = 5'h0F;  // phase 0 closing edge shifts nothing

    // ==========================================================
    // rate divider
    localparam logic [2:0] RATE_CODE_TOP = 3'h6;    // code 7 falls back to this one
    localparam logic [7:0] HALF_DIV_BASE = 8'h02;   // half bit time at divide by 4

    // ==========================================================
    // pin handover masks: bit0 receive, bit1 transmit, bit2 clock, bit3 select
    localparam logic [3:0] PINS_NONE   = 4'h0;
    localparam logic [3:0] PINS_MASTER = 4'h7;
    localparam logic [3:0] PINS_SLAVE  = 4'hF;

endpackage

// ### rate_divider.sv
// restartable divider giving one tick per half serial bit time
module rate_divider (
    input  wire logic       clk_in,         // processor clock
    input  wire logic       rst_n_in,       // synchronous reset, active low
    input  wire logic       run_in,         // count only while a master frame runs
    input  wire logic       restart_in,     // new load: start a fresh half period
    input  wire logic [2:0] rate_sel_in,    // divide select code
    output logic            tick_out        // one-cycle half-period pulse
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] cnt;                    // cycles into the current half period
        logic       tick;                   // registered tick
    } div_state_t;

    div_state_t q;                          // registered state
    div_state_t n;                          // next state
    logic [2:0] code;                       // effective select code
    logic [7:0] half;                       // half bit time in clock cycles

    // ==========================================================
    // next state: the count is held at zero while idle, so every frame starts aligned
    always_comb begin
        n = q;
        // undefined top code is treated as the slowest rate
        code = (rate_sel_in > ssc_pkg::RATE_CODE_TOP) ? ssc_pkg::RATE_CODE_TOP : rate_sel_in;
        half = ssc_pkg::HALF_DIV_BASE << code;
        n.tick = 1'b0;
        if (restart_in || !run_in) begin
            n.cnt = 8'h00;
        end else if (q.cnt == 8'(half - 8'h01)) begin
            n.cnt = 8'h00;
            n.tick = 1'b1;
        end else begin
            n.cnt = 8'(q.cnt + 8'h01);
        end
    end

    // register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tick_out = q.tick;

    // ==========================================================
    // checks
    a_restart_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        restart_in |=> !tick_out ##1 !tick_out)
        else $error("divider ticked too soon after restart");
endmodule

// ### sync_serial_channel.sv
// byte-wide synchronous serial channel, master or slave, with collision shadow
module sync_serial_channel (
    input  wire logic       CORE_CLK_IN,              // processor clock, 20 MHz
    input  wire logic       RST_N_IN,                 // synchronous reset, active low
    input  wire logic       CHANNEL_ENABLE_IN,        // global enable
    input  wire logic       MASTER_SELECT_IN,         // 1 master, 0 slave
    input  wire logic       CLOCK_IDLE_POLARITY_IN,   // idle level of the serial clock
    input  wire logic       CLOCK_PHASE_SELECT_IN,    // 0 sample on leading edge
    input  wire logic       SLAVE_TRANSMIT_ENABLE_IN, // slave drives data out when 1
    input  wire logic [2:0] RATE_SELECT_IN,           // master divide select
    input  wire logic       LSB_FIRST_IN,             // 1 shifts lsb first
    input  wire logic       INT_ENABLE_IN,            // gates the interrupt request
    input  wire logic       TX_WRITE_IN,              // transmit buffer write strobe
    input  wire logic [7:0] TX_DATA_IN,               // transmit buffer write data
    input  wire logic       TC_CLEAR_IN,              // clears the complete flag
    input  wire logic       WRITE_COLLISION_FLAG_CLEAR_IN,            // clears the collision flag
    input  wire logic       SERIAL_RECEIVE_IN,        // receive data pin
    input  wire logic       SCLK_IN,                  // clock pin level
    input  wire logic       SLAVE_SELECT_N_IN,        // select pin, active low
    output logic [7:0]      RECEIVE_BUFFER_OUT,       // last received byte
    output logic [7:0]      TRANSMIT_SHADOW_OUT,      // data of the last colliding write
    output logic            TRANSFER_COMPLETE_OUT,    // sticky complete flag
    output logic            WRITE_COLLISION_OUT,      // sticky collision flag
    output logic            IRQ_OUT,                  // interrupt request
    output logic            BUSY_OUT,                 // transfer in progress
    output logic            SCLK_OUT,                 // clock pin drive value
    output logic            SCLK_OE_OUT,              // clock pin driven
    output logic            SERIAL_TRANSMIT_OUT,      // transmit pin drive value
    output logic            SERIAL_TRANSMIT_OE_OUT,   // transmit pin driven
    output logic [3:0]      PINS_OWNED_OUT            // pins taken from the port
);
    // ==========================================================
    // state record
    typedef struct packed {
        ssc_pkg::chan_state_t st;           // controller state
        logic [7:0] shift;                  // the shift register
        logic [7:0] rxbuf;                  // receive buffer
        logic [7:0] shadow;                 // collision shadow
        logic [4:0] edges;                  // master ticks into the frame
        logic [3:0] bits;                   // samples taken this byte
        logic       started;                // frame past its start point
        logic       sclk;                   // master clock level
        logic       tx_bit;                 // transmit pin value
        logic       tc;                     // complete flag
        logic       write_collision_flag;                   // collision flag
        logic       irq;                    // interrupt request
        logic [2:0] sclk_sync;              // clock pin synchroniser plus history
        logic [2:0] sel_sync;               // select pin synchroniser plus history
        logic [1:0] rx_sync;                // data pin synchroniser
    } ch_state_t;

    localparam ch_state_t STATE_RST = '{st: ssc_pkg::ST_IDLE, tx_bit: 1'b1,
                                        sel_sync: 3'h7, default: '0};

    ch_state_t q;                           // registered state
    ch_state_t n;                           // next state

    logic       en;                         // channel enabled
    logic       master;                     // master role
    logic       pol;                        // idle clock level
    logic       clock_phase_select;                       // clock phase
    logic       sel_act;                    // synchronised select, active
    logic       sel_prev;                   // select one cycle earlier
    logic       busy;                       // collision window open
    logic       wr_ok;                      // write that loads the register
    logic       wr_col;                     // write that collides
    logic       tick;                       // half-bit pulse from the divider
    logic       m_edge;                     // master clock edge this cycle
    logic       s_edge;                     // slave clock edge seen this cycle
    logic       lead;                       // the edge leaves the idle level
    logic       do_sample;                  // sampling edge
    logic       do_shift;                   // shifting edge
    logic       tc_set;                     // eighth sample taken
    logic [7:0] rx_word;                    // register after this sample
    logic       rx_bit;                     // synchronised receive data

    // ==========================================================
    // bit order helpers
    function automatic logic out_bit(input logic [7:0] s, input logic lsb);
        out_bit = lsb ? s[0] : s[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b,
                                            input logic lsb);
        shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
    endfunction

    // ==========================================================
    // baud rate generation
    rate_divider u_div (
        .clk_in      (CORE_CLK_IN),
        .rst_n_in    (RST_N_IN),
        .run_in      (en && master && (q.st == ssc_pkg::ST_MRUN)),
        .restart_in  (wr_ok && master),
        .rate_sel_in (RATE_SELECT_IN),
        .tick_out    (tick)
    );

    // ==========================================================
    // decode of the current cycle
    always_comb begin
        en       = CHANNEL_ENABLE_IN;
        master   = MASTER_SELECT_IN;
        pol      = CLOCK_IDLE_POLARITY_IN;
        clock_phase_select     = CLOCK_PHASE_SELECT_IN;
        sel_act  = !q.sel_sync[1];
        sel_prev = !q.sel_sync[2];
        // limitation: a master at divide by 4 samples before the two-flop receive
        // path has caught up with the peer's last shift; divide by 8 or slower is safe
        rx_bit   = q.rx_sync[1];
        // slave phase 0 is busy for the whole select, all else from start to last sample
        busy     = (!master && !clock_phase_select) ? sel_act : q.started;
        wr_ok    = TX_WRITE_IN && en && !busy;
        wr_col   = TX_WRITE_IN && en && busy;
        // master edges come from the divider, slave edges from the pin
        m_edge   = master && (q.st == ssc_pkg::ST_MRUN) && tick
                   && (q.edges < ssc_pkg::EDGES_PER_FRAME);
        // select must have stood a cycle: the clock history leaves reset at 0, so a
        // pin idling high would otherwise look like an edge straight after reset
        s_edge   = !master && (q.st == ssc_pkg::ST_SRUN) && sel_act && sel_prev
                   && (q.sclk_sync[1] != q.sclk_sync[2]);
        lead     = m_edge ? (q.sclk == pol) : (q.sclk_sync[1] != pol);
        do_sample = (m_edge || s_edge) && (lead ^ clock_phase_select);
        do_shift  = (m_edge || s_edge) && !(lead ^ clock_phase_select)
                    && !(m_edge && (q.edges == ssc_pkg::NO_SHIFT_TICK));
        rx_word  = shift_in(q.shift, rx_bit, LSB_FIRST_IN);
        tc_set   = do_sample && (q.bits == ssc_pkg::LAST_BIT_IDX);
    end

    // ==========================================================
    // next state
    always_comb begin
        n = q;
        n.sclk_sync = {q.sclk_sync[1:0], SCLK_IN};
        n.sel_sync  = {q.sel_sync[1:0], SLAVE_SELECT_N_IN};
        n.rx_sync   = {q.rx_sync[0], SERIAL_RECEIVE_IN};

        // role sequencing
        case (q.st)
            ssc_pkg::ST_IDLE: begin
                if (!master) begin
                    n.st = ssc_pkg::ST_SRUN;
                end else begin
                    n.sclk   = pol;
                    n.tx_bit = 1'b1;
                end
            end
            ssc_pkg::ST_MRUN: begin
                if (tick) begin
                    if (m_edge) begin
                        n.sclk = !q.sclk;
                    end
                    n.edges = 5'(q.edges + 5'h01);
                    // last bit has stood a full bit time: idle the line high
                    if (q.edges == (clock_phase_select ? ssc_pkg::TAIL_TICK_PH1
                                         : ssc_pkg::TAIL_TICK_PH0)) begin
                        n.tx_bit = 1'b1;
                        n.st     = ssc_pkg::ST_IDLE;
                    end
                end
            end
            ssc_pkg::ST_SRUN: begin
                if (sel_act && !sel_prev) begin
                    n.tx_bit = out_bit(q.shift, LSB_FIRST_IN); // phase 0 first bit
                end
                if (!sel_act) begin
                    // deselect drops any partial byte without flagging it
                    n.bits    = 4'h0;
                    n.started = 1'b0;
                end
            end
            default: begin
                n.st = ssc_pkg::ST_IDLE;
            end
        endcase

        // data movement on clock edges
        if (do_shift) begin
            n.tx_bit  = out_bit(q.shift, LSB_FIRST_IN);
            n.started = 1'b1;
        end
        if (do_sample) begin
            n.shift   = rx_word;
            n.bits    = 4'(q.bits + 4'h1);
            n.started = 1'b1;
        end
        if (tc_set) begin
            n.rxbuf   = rx_word;
            n.bits    = 4'h0;
            n.started = 1'b0;
        end

        // processor writes
        if (wr_ok) begin
            n.shift = TX_DATA_IN;
            n.bits  = 4'h0;
            if (master) begin
                n.st      = ssc_pkg::ST_MRUN;
                n.edges   = 5'h00;
                n.sclk    = pol;
                n.started = !clock_phase_select;
                // phase 0 shows its first bit at once, phase 1 on the first edge
                n.tx_bit  = clock_phase_select ? q.tx_bit : out_bit(TX_DATA_IN, LSB_FIRST_IN);
            end else if (!clock_phase_select) begin
                n.tx_bit = out_bit(TX_DATA_IN, LSB_FIRST_IN);
            end
        end
        if (wr_col) begin
            n.shadow = TX_DATA_IN;
        end

        // sticky flags: a new event beats a clear in the same cycle
        n.tc   = (q.tc && !TC_CLEAR_IN) || tc_set;
        n.write_collision_flag = (q.write_collision_flag && !WRITE_COLLISION_FLAG_CLEAR_IN) || wr_col;
        n.irq  = n.tc && INT_ENABLE_IN;

        // global disable wins over everything but the flags and buffers
        if (!en) begin
            n.st      = ssc_pkg::ST_IDLE;
            n.edges   = 5'h00;
            n.bits    = 4'h0;
            n.started = 1'b0;
            n.sclk    = pol;
            n.tx_bit  = 1'b1;
        end
    end

    // register
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            q <= STATE_RST;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs
    assign RECEIVE_BUFFER_OUT    = q.rxbuf;
    assign TRANSMIT_SHADOW_OUT   = q.shadow;
    assign TRANSFER_COMPLETE_OUT = q.tc;
    assign WRITE_COLLISION_OUT   = q.write_collision_flag;
    assign IRQ_OUT               = q.irq;
    assign BUSY_OUT              = busy;
    assign SCLK_OUT              = q.sclk;
    assign SERIAL_TRANSMIT_OUT   = q.tx_bit;

    // pin ownership; the select pin stays a port pin for a master
    always_comb begin
        SCLK_OE_OUT            = en && master;
        SERIAL_TRANSMIT_OE_OUT = en && (master
                                 || (SLAVE_TRANSMIT_ENABLE_IN && sel_act));
        if (!en) begin
            PINS_OWNED_OUT = ssc_pkg::PINS_NONE;
        end else if (master) begin
            PINS_OWNED_OUT = ssc_pkg::PINS_MASTER;
        end else begin
            PINS_OWNED_OUT = ssc_pkg::PINS_SLAVE;
        end
    end

    // ==========================================================
    // checks
    a_master_load_start: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (en && master && wr_ok) |=> (q.st == ssc_pkg::ST_MRUN) && (q.edges == 5'h00)
                                    && (q.shift == $past(TX_DATA_IN)))
        else $error("master write did not start a frame");

    a_first_edge_late: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (en && master && wr_ok && $stable(pol)) |=> (SCLK_OUT == pol) ##1 $stable(SCLK_OUT))
        else $error("first clock edge came too early");

    a_complete_copy: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        tc_set |=> TRANSFER_COMPLETE_OUT && (RECEIVE_BUFFER_OUT == $past(rx_word))
                   ##1 (IRQ_OUT == $past(INT_ENABLE_IN)))
        else $error("eighth bit did not complete the byte");

    a_collision_hold: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (wr_col && !do_sample && en) |=> WRITE_COLLISION_OUT && $stable(q.shift))
        else $error("colliding write disturbed the transfer");

    a_shadow_value: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        wr_col |=> (TRANSMIT_SHADOW_OUT == $past(TX_DATA_IN)))
        else $error("shadow lost colliding data");

    a_disable_release: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        !en |=> (q.st == ssc_pkg::ST_IDLE) && (q.bits == 4'h0) && !q.started)
        else $error("disable did not stop the channel");

    a_master_pins: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (en && master) |-> SCLK_OE_OUT && SERIAL_TRANSMIT_OE_OUT
                           && (PINS_OWNED_OUT == ssc_pkg::PINS_MASTER))
        else $error("master does not own its pins");

    a_slave_out_off: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (en && !master && (!SLAVE_TRANSMIT_ENABLE_IN || SLAVE_SELECT_N_IN)
         && $past(SLAVE_SELECT_N_IN) && $past(SLAVE_SELECT_N_IN, 2))
        |-> !SERIAL_TRANSMIT_OE_OUT)
        else $error("slave drives data while not allowed");

    a_idle_line_high: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (en && master && (q.st == ssc_pkg::ST_IDLE)) |-> SERIAL_TRANSMIT_OUT)
        else $error("master idle line not high");

    a_slave_hold: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (en && !master && !sel_act && !wr_ok) |=> $stable(q.shift))
        else $error("deselected slave changed its register");

    a_abort_no_flag: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (en && !master && sel_prev && !sel_act && (q.bits != 4'h0) && !tc_set)
        |=> (q.bits == 4'h0) && !$rose(TRANSFER_COMPLETE_OUT))
        else $error("aborted byte left count or flag");

    a_phase1_load_idle: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (en && master && clock_phase_select && wr_ok) |=> !BUSY_OUT)
        else $error("phase 1 load opened the busy window early");

    a_slave_sel_busy: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (en && !master && !clock_phase_select && sel_act && TX_WRITE_IN) |=> WRITE_COLLISION_OUT)
        else $error("slave write under select did not collide");
endmodule

// ### spi_peer_model.sv
// far-side serial peripheral that returns a reply byte during a master frame
module spi_peer_model (
    input  wire logic       sclk_in,   // clock pin level from the master
    input  wire logic       mosi_in,   // data pin from the master
    input  wire logic       pol_in,    // idle clock level
    input  wire logic       pha_in,    // 0 samples on the leading edge
    input  wire logic       load_in,   // rising edge arms a new reply
    input  wire logic [7:0] reply_in,  // byte sent back, msb first
    output logic            miso_out,  // data towards the master
    output logic [7:0]      got_out    // byte taken from the master
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx_q = 8'h00;          // bits still to send
    initial miso_out = 1'b0;
    initial got_out = 8'h00;
    // ==========================================================
    // phase 0 shows the first bit at once, phase 1 waits for the first edge
    always @(posedge load_in) begin
        tx_q = pha_in ? reply_in : {reply_in[6:0], 1'b0};
        miso_out = pha_in ? ~reply_in[7] : reply_in[7];
    end
    // sample on one kind of edge, shift on the other; stray edges before a load do no harm
    always @(sclk_in) begin
        if ((sclk_in != pol_in) != pha_in) got_out = {got_out[6:0], mosi_in};
        else begin
            miso_out = tx_q[7];
            tx_q = {tx_q[6:0], ~tx_q[0]}; // changing filler, never a stale level
        end
    end
endmodule

// ### sync_serial_channel_tb.sv
// self-checking bench for the serial channel in master and slave roles
module sync_serial_channel_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // stimulus and observed signals
    logic       clk = 1'b0, rst_n = 1'b0, en = 1'b0, mst = 1'b1, pol = 1'b0, pha = 1'b0;
    logic       wr = 1'b0, tcc = 1'b0, wcc = 1'b0, sel_n = 1'b1, ld = 1'b0, ien = 1'b1;
    logic       slave_transmit_enable = 1'b1, lsb = 1'b0, s_clk = 1'b0; // slave tx enable, bit order, bench clock
    logic [2:0] rate = 3'h1;                      // divide by 8 leaves margin for rx sync
    logic [7:0] wd = 8'h00, reply = 8'h00, rbuf, shadow, got;
    logic       tc, write_collision_flag, irq, busy, sclk, sclk_oe, tx, tx_oe, miso;
    logic [3:0] pins;
    int         err_total = 0, n_compared = 0, n;
    wire        sclk_pin = sclk_oe ? sclk : (pol ^ s_clk); // bench clocks a slave
    wire        mosi_pin = tx_oe ? tx : 1'b1;     // pull-up when released
    initial forever #25 clk = ~clk;
    sync_serial_channel i_dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CHANNEL_ENABLE_IN(en),
        .MASTER_SELECT_IN(mst), .CLOCK_IDLE_POLARITY_IN(pol), .CLOCK_PHASE_SELECT_IN(pha),
        .SLAVE_TRANSMIT_ENABLE_IN(slave_transmit_enable), .RATE_SELECT_IN(rate), .LSB_FIRST_IN(lsb),
        .INT_ENABLE_IN(ien), .TX_WRITE_IN(wr), .TX_DATA_IN(wd), .TC_CLEAR_IN(tcc),
        .WRITE_COLLISION_FLAG_CLEAR_IN(wcc), .SERIAL_RECEIVE_IN(miso), .SCLK_IN(sclk_pin),
        .SLAVE_SELECT_N_IN(sel_n), .RECEIVE_BUFFER_OUT(rbuf), .TRANSMIT_SHADOW_OUT(shadow),
        .TRANSFER_COMPLETE_OUT(tc), .WRITE_COLLISION_OUT(write_collision_flag), .IRQ_OUT(irq),
        .BUSY_OUT(busy), .SCLK_OUT(sclk), .SCLK_OE_OUT(sclk_oe), .SERIAL_TRANSMIT_OUT(tx),
        .SERIAL_TRANSMIT_OE_OUT(tx_oe), .PINS_OWNED_OUT(pins));
    spi_peer_model i_peer (.sclk_in(sclk_pin), .mosi_in(mosi_pin), .pol_in(pol), .pha_in(pha),
        .load_in(ld), .reply_in(reply), .miso_out(miso), .got_out(got));
    // ==========================================================
    // shared tasks: inputs always move 5 ns after the rising edge
    task automatic step(); @(posedge clk); #5; endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [7:0] d); step(); wd = d; wr = 1'b1; step(); wr = 1'b0; endtask
    task automatic xfer(input logic [7:0] d, input logic [7:0] r);
        reply = r; ld = 1'b1; send(d); ld = 1'b0;
    endtask
    task automatic wait_lvl(input logic v); // bounded wait for the clock pin
        n = 0;
        while (sclk !== v && n < 600) begin step(); n++; end
    endtask
    // completion: flag and interrupt rise together, both checked one cycle later, then clear
    task automatic wait_tc();
        n = 0;
        while (tc !== 1'b1 && n < 5000) begin step(); n++; end
        step();
        chk({6'h00, irq, tc}, 8'h03);
        tcc = 1'b1; step(); tcc = 1'b0;
    endtask
    task automatic slave_clk(input int k); // k clock edges, six cycles apart, under the caller's select
        repeat (k) begin
            s_clk = ~s_clk;
            repeat (6) step();
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ==========================================================
    // hang guard, well beyond the longest frame sequence
    initial begin
        #1500000;
        err_total++;
        tally_and_finish();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) step();
        rst_n = 1'b1;
        chk(rbuf, 8'h00);
        chk({4'h0, pins}, {4'h0, ssc_pkg::PINS_NONE});
        for (int m = 0; m < 4; m++) begin
            en = 1'b0; {pol, pha} = m[1:0]; step();
            en = 1'b1; step(); // role fixed before enable
            chk({4'h0, pins}, {4'h0, ssc_pkg::PINS_MASTER});
            xfer(8'hA5 ^ m[7:0], 8'h3C + m[7:0]);
            if (m == 0) begin
                send(8'h5A);
                step();
                chk({7'h00, write_collision_flag}, 8'h01);
                chk(shadow, 8'h5A);
                wcc = 1'b1; step(); wcc = 1'b0;
            end
            wait_tc();
            chk(rbuf, 8'h3C + m[7:0]);
            chk(got, 8'hA5 ^ m[7:0]);
            repeat (12) step();
            chk({6'h00, sclk, tx}, {6'h00, pol, 1'b1});
        end
        $display("test modes done");
        en = 1'b0; {pol, pha} = 2'b00; step(); en = 1'b1;
        for (int c = 0; c < 8; c++) begin
            rate = c[2:0]; step();
            xfer(8'h81, 8'h18);
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            chk(n[7:0], 8'h02 << ((c > 6) ? 6 : c));
            wait_tc();
        end
        $display("test rates done");
        rate = 3'h1; xfer(8'hF0, 8'h0F);
        repeat (10) step();
        en = 1'b0; step();
        chk({3'h0, busy, pins}, {4'h0, ssc_pkg::PINS_NONE});
        repeat (100) step();
        chk({7'h00, tc}, 8'h00);
        mst = 1'b0; step(); en = 1'b1; step();
        chk({3'h0, tx_oe, pins}, {4'h0, ssc_pkg::PINS_SLAVE});
        slave_transmit_enable = 1'b0;
        sel_n = 1'b0;
        repeat (4) step();
        chk({7'h00, tx_oe}, 8'h00);
        slave_transmit_enable = 1'b1;
        sel_n = 1'b0; repeat (4) step();
        chk({7'h00, tx_oe}, 8'h01);
        sel_n = 1'b1; repeat (4) step();
        $display("test pins done");
        // slave byte clocked by the bench: loaded byte goes out, reply comes in
        reply = 8'h96;
        ld = 1'b1;
        send(8'hC3);
        ld = 1'b0;
        sel_n = 1'b0;
        repeat (4) step();
        slave_clk(16);
        wait_tc();
        chk(rbuf, 8'h96);
        chk(got, 8'hC3);
        // phase 0: the whole select time counts as busy
        send(8'h3E);
        step();
        chk({7'h00, write_collision_flag}, 8'h01);
        chk(shadow, 8'h3E);
        wcc = 1'b1;
        step();
        wcc = 1'b0;
        sel_n = 1'b1;
        repeat (4) step();
        // two bits then deselect: no flag, and the next byte counts from zero
        sel_n = 1'b0;
        repeat (4) step();
        slave_clk(4);
        sel_n = 1'b1;
        repeat (4) step();
        chk({7'h00, tc}, 8'h00);
        reply = 8'h12;
        lsb = 1'b1;
        ld = 1'b1;
        sel_n = 1'b0;
        repeat (4) step();
        slave_clk(16);
        wait_tc();
        chk(rbuf, 8'h48);
        ld = 1'b0;
        sel_n = 1'b1;
        repeat (4) step();
        $display("test slave done");
        tally_and_finish();
    end
endmodule
